// File: rtl/atf_pkg.sv
// Constants, carriers and state codes for the task file register port.
// Assumes one 40 MHz clock and a synchronous active-high reset.
//
// Contract
// [R1] Command block, DA 0..7: data, error/feature, count, address bytes, status/command.
// [R2] Control block DA 6 reads alternate status, writes device control; others silent.
// [R3] Host never asserts both chip selects; that address is invalid.
// [R4] Obsolete control address 7 gets no read response, so bit 7 is never driven.
// [R5] From command write until ending status, busy or data request stays set.
// [R6] While busy or data request is set, only those two status bits mean anything.
// [R7] Host writes no command block register while busy or data request is set.
// [R8] Busy and data request clear within 400 ns of the final PIO word.
// [R9] LBA bits come from sector number, cylinder low, high and device/head nibble.
// [R10] Even data byte is mirrored at offset 08h, odd data byte at 09h.
// [R11] Error/feature is mirrored at 0Dh, low lane, or high lane at 0Ch/0Dh.
// [R12] Even byte on D7-D0 at 0h/8h; both enables low moves a whole word.
// [R13] Odd byte on D7-D0 at 9h, or on D15-D8 with only CE2# low.
// [R14] Reset and diagnostics load count 01h, number 01h, cylinders 00h, head A0h.
// [R15] Only the device matching the DEV bit executes a written command.
// [R16] Pending interrupt clears on reset, SRST, command write or status read; a status read on the D15-D8 lane leaves it set.
// [R17] Alternate status reads like status but changes no state.
// [R18] Data bus is driven only during a read of a decoded readable address.
package atf_pkg;

   // ====================================================================
   // Timing
   localparam int CLK_PERIOD_NS = 25;
   localparam int CLEAR_LIMIT_NS = 400;
   // Longest time, so it rounds down; the logic clears three clock edges after the strobe rises.
   localparam int CLEAR_LIMIT_CYC = CLEAR_LIMIT_NS / CLK_PERIOD_NS;

   // ====================================================================
   // Offsets on the unified byte map
   localparam logic [3:0] OFF_DATA = 4'h0;
   localparam logic [3:0] OFF_ERRFEAT = 4'h1;
   localparam logic [3:0] OFF_COUNT = 4'h2;
   localparam logic [3:0] OFF_SECNUM = 4'h3;
   localparam logic [3:0] OFF_CYLLO = 4'h4;
   localparam logic [3:0] OFF_CYLHI = 4'h5;
   localparam logic [3:0] OFF_DEVHEAD = 4'h6;
   localparam logic [3:0] OFF_STATCMD = 4'h7;
   localparam logic [3:0] OFF_DUP_EVEN = 4'h8;
   localparam logic [3:0] OFF_DUP_ODD = 4'h9;
   localparam logic [3:0] OFF_ERRFEAT_COPY = 4'hd;
   localparam logic [3:0] OFF_ALTCTL = 4'he;
   localparam logic [2:0] ATA_CTL_DA = 3'h6;

   // ====================================================================
   // Values after reset and diagnostics
   localparam logic [7:0] RST_COUNT = 8'h01;
   localparam logic [7:0] RST_SECNUM = 8'h01;
   localparam logic [7:0] RST_CYLLO = 8'h00;
   localparam logic [7:0] RST_CYLHI = 8'h00;
   localparam logic [7:0] RST_DEVHEAD = 8'ha0;

   // ====================================================================
   // Field positions and opcodes
   localparam int DEVHEAD_DEV_BIT = 4;
   localparam int DEVCTL_SRST_BIT = 2;
   localparam int DEVCTL_NIEN_BIT = 1;
   localparam int STAT_BSY_BIT = 7;
   localparam int STAT_DRDY_BIT = 6;
   localparam int STAT_DSC_BIT = 4;
   localparam int STAT_DRQ_BIT = 3;
   localparam int STAT_ERR_BIT = 0;
   localparam logic [7:0] CMD_DIAG = 8'h90;
   localparam int FIFO_WIDTH = 16;
   localparam int FIFO_DEPTH = 8;

   // ====================================================================
   // Carriers
   typedef struct packed {
      logic cs0_n;
      logic cs1_n;
      logic [2:0] da;
      logic dior_n;
      logic diow_n;
      logic ce1_n;
      logic ce2_n;
      logic [3:0] addr;
      logic [15:0] dd;
   } atf_pins_type;

   typedef struct packed {
      logic [7:0] opcode;
      logic [7:0] features;
      logic [7:0] count;
      logic [27:0] lba;
   } atf_task_type;

   typedef enum logic [2:0] {
      PH_IDLE = 3'h1,
      PH_BUSY = 3'h2,
      PH_XFER = 3'h4
   } atf_phase_type;

endpackage

// File: rtl/atf_task_file_port.sv
// Task file register port and its write data FIFO.
// Host pins arrive asynchronously and are synchronised here; the command
// engine side runs on ref_clk.
`timescale 1ns/100ps

// ========================================================================
// Write data FIFO
module atf_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8
) (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
      logic ov;
      logic [WIDTH-1:0] od;
   } atf_fifo_state_type;

   atf_fifo_state_type r;
   atf_fifo_state_type n;
   logic do_in;
   logic do_out;

   assign in_ready = r.cnt != (AW+1)'(DEPTH);
   // Registered copies keep the stream outputs straight from flip-flops.
   assign out_valid = r.ov;
   assign out_data = r.od;

   always_comb begin
      n = r;
      do_in = in_valid && in_ready;
      do_out = out_valid && out_ready;
      if (do_in) begin
         n.mem[r.wp] = in_data;
         n.wp = (r.wp == AW'(DEPTH - 1)) ? '0 : r.wp + AW'(1);
      end
      if (do_out) begin
         n.rp = (r.rp == AW'(DEPTH - 1)) ? '0 : r.rp + AW'(1);
      end
      n.cnt = r.cnt + (AW+1)'(do_in) - (AW+1)'(do_out);
      if (srst) begin
         n = '0;
      end
      n.ov = n.cnt != '0;
      n.od = n.mem[n.rp];
   end

   always_ff @(posedge ref_clk) begin
      r <= n;
   end
endmodule

// ========================================================================
// Register port
module atf_task_file_port
   import atf_pkg::*;
(
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic pcc_mode,
   input wire logic dev_id,
   input wire atf_pins_type pins,
   output logic [15:0] dd_out,
   output logic [1:0] dd_oe,
   output logic intrq,
   output atf_task_type task_out,
   output logic cmd_valid,
   input wire logic xfer_start,
   input wire logic xfer_read,
   input wire logic [15:0] xfer_words,
   input wire logic cmd_done,
   input wire logic [7:0] cmd_err_code,
   input wire logic rd_valid,
   input wire logic [15:0] rd_data,
   output logic rd_ready,
   output logic wd_valid,
   output logic [15:0] wd_data,
   input wire logic wd_ready
);

   typedef struct packed {
      atf_pins_type s1;
      atf_pins_type s2;
      logic [1:0] mode_s;
      logic [1:0] dev_s;
      logic dior_d;
      logic diow_d;
      logic acc_lo;
      logic acc_hi;
      logic acc_dw;
      logic [3:0] acc_loff;
      logic [3:0] acc_hoff;
      logic [15:0] acc_dd;
      atf_phase_type phase;
      logic [7:0] feat;
      logic [7:0] err;
      logic err_flag;
      logic [7:0] count;
      logic [7:0] secnum;
      logic [7:0] cyllo;
      logic [7:0] cylhi;
      logic [7:0] devhead;
      logic [7:0] opcode;
      logic [7:0] devctl;
      logic [7:0] wr_lo;
      logic [15:0] words_left;
      logic xfer_rd;
      logic pend;
      logic [15:0] dd_out;
      logic [1:0] dd_oe;
      logic intrq;
      logic cmd_valid;
      logic rd_ready;
      logic push;
      logic [15:0] push_data;
   } atf_top_type;

   atf_top_type r;
   atf_top_type n;
   logic fifo_in_ready;

   function automatic atf_top_type with_defaults(input atf_top_type x);
      atf_top_type y;
      y = x;
      y.count = RST_COUNT; // R14
      y.secnum = RST_SECNUM;
      y.cyllo = RST_CYLLO;
      y.cylhi = RST_CYLHI;
      y.devhead = RST_DEVHEAD;
      return y;
   endfunction

   // Bit 8 of the result tells whether the offset answers a read at all.
   function automatic logic [8:0] rd_byte(input logic [3:0] off,
      input atf_top_type x, input logic [7:0] stat,
      input logic [15:0] rdat);
      case (off)
         OFF_DATA, OFF_DUP_EVEN: return {1'b1, rdat[7:0]}; // R10
         OFF_DUP_ODD: return {1'b1, rdat[15:8]}; // R13
         OFF_ERRFEAT, OFF_ERRFEAT_COPY: return {1'b1, x.err}; // R11
         OFF_COUNT: return {1'b1, x.count};
         OFF_SECNUM: return {1'b1, x.secnum};
         OFF_CYLLO: return {1'b1, x.cyllo};
         OFF_CYLHI: return {1'b1, x.cylhi};
         OFF_DEVHEAD: return {1'b1, x.devhead};
         OFF_STATCMD, OFF_ALTCTL: return {1'b1, stat}; // R17
         default: return 9'h000;
      endcase
   endfunction

   atf_fifo #(
      .WIDTH(FIFO_WIDTH),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .ref_clk(ref_clk),
      .srst(srst),
      .in_valid(r.push),
      .in_ready(fifo_in_ready),
      .in_data(r.push_data),
      .out_valid(wd_valid),
      .out_ready(wd_ready),
      .out_data(wd_data)
   );

   logic acc_ok;
   logic lo_en;
   logic hi_en;
   logic data_word;
   logic [3:0] lo_off;
   logic [3:0] hi_off;
   logic [8:0] lo_r;
   logic [8:0] hi_r;
   logic drq;
   logic bsy;
   logic [7:0] stat;
   logic dior_rise;
   logic diow_rise;
   logic do_push;
   logic do_cmd;
   logic lane_en;
   logic [3:0] lane_off;
   logic [7:0] lane_val;
   logic [15:0] push_word;
   logic [7:0] cmd_byte;
   atf_pins_type p;

   always_comb begin
      n = r;
      p = r.s2;
      n.s1 = pins;
      n.s2 = r.s1;
      n.mode_s = {r.mode_s[0], pcc_mode};
      n.dev_s = {r.dev_s[0], dev_id};
      n.dior_d = p.dior_n;
      n.diow_d = p.diow_n;
      n.cmd_valid = 1'b0;
      n.rd_ready = 1'b0;
      n.push = 1'b0;
      acc_ok = 1'b0;
      lo_en = 1'b0;
      hi_en = 1'b0;
      data_word = 1'b0;
      lo_off = OFF_DATA;
      hi_off = OFF_ERRFEAT;
      do_push = 1'b0;
      do_cmd = 1'b0;
      lane_en = 1'b0;
      lane_off = OFF_DATA;
      lane_val = 8'h00;
      push_word = 16'h0000;
      cmd_byte = 8'h00;

      // ==================================================================
      // Address decode onto one byte map for both access styles.
      if (!r.mode_s[1]) begin
         if (!p.cs0_n && p.cs1_n) begin
            acc_ok = 1'b1; // R1
            lo_en = 1'b1;
            lo_off = {1'b0, p.da};
            hi_en = p.da == OFF_DATA[2:0];
            data_word = hi_en;
         end else if (p.cs0_n && !p.cs1_n && p.da == ATA_CTL_DA) begin
            acc_ok = 1'b1; // R2
            lo_en = 1'b1;
            lo_off = OFF_ALTCTL;
         end
         // Both selects, other control addresses and DA 7 stay silent.
         // R3 R4
      end else begin
         lo_en = !p.ce1_n; // R12
         hi_en = !p.ce2_n; // R13
         acc_ok = lo_en || hi_en;
         lo_off = hi_en ? {p.addr[3:1], 1'b0} : p.addr;
         hi_off = {p.addr[3:1], 1'b1};
         data_word = lo_en && hi_en && p.addr[2:1] == 2'h0; // R12
      end

      // ==================================================================
      // Status. Only the busy and request bits are trustworthy while either
      // is set; DRDY still follows !bsy, DSC stays set and ERR shows err_flag. R6
      drq = r.phase == PH_XFER && (r.xfer_rd ? rd_valid : fifo_in_ready);
      bsy = r.phase == PH_BUSY || (r.phase == PH_XFER && !drq); // R5
      stat = 8'h00;
      stat[STAT_BSY_BIT] = bsy;
      stat[STAT_DRDY_BIT] = !bsy;
      stat[STAT_DSC_BIT] = 1'b1;
      stat[STAT_DRQ_BIT] = drq;
      stat[STAT_ERR_BIT] = r.err_flag;

      lo_r = rd_byte(lo_off, r, stat, rd_data);
      hi_r = data_word ? {1'b1, rd_data[15:8]} :
         rd_byte(hi_off, r, stat, rd_data);
      n.dd_out = {hi_r[7:0], lo_r[7:0]};
      n.dd_oe = p.dior_n ? 2'h0 :
         {acc_ok && hi_en && hi_r[8], acc_ok && lo_en && lo_r[8]}; // R18

      // Decode and data are captured while a strobe is low and kept after it rises, because the
      // synchronised address may already move by the time the rising
      // edge is seen.
      if (!p.dior_n || !p.diow_n) begin
         n.acc_lo = acc_ok && lo_en;
         n.acc_hi = acc_ok && hi_en;
         n.acc_dw = acc_ok && data_word;
         n.acc_loff = lo_off;
         n.acc_hoff = hi_off;
         n.acc_dd = p.dd;
      end
      dior_rise = p.dior_n && !r.dior_d;
      diow_rise = p.diow_n && !r.diow_d;

      // ==================================================================
      // Read side effects.
      if (dior_rise) begin
         if (r.acc_lo && r.acc_loff == OFF_STATCMD) begin
            n.pend = 1'b0; // R16
         end
         if ((r.acc_dw || (r.acc_hi && r.acc_hoff == OFF_DUP_ODD) ||
             (r.acc_lo && r.acc_loff == OFF_DUP_ODD)) &&
             r.phase == PH_XFER && r.xfer_rd && rd_valid) begin
            n.rd_ready = 1'b1;
            n.words_left = r.words_left - 16'h0001;
            if (r.words_left == 16'h0001) begin
               n.phase = PH_IDLE; // R8
               n.pend = 1'b1;
            end
         end
      end

      // ==================================================================
      // Writes: data-word accesses push the whole word, others go one byte lane at a time.
      if (diow_rise) begin
         if (r.acc_dw) begin
            do_push = 1'b1;
            push_word = r.acc_dd;
         end else begin
            for (int l = 0; l < 2; l++) begin
               lane_en = (l == 0) ? r.acc_lo : r.acc_hi;
               lane_off = (l == 0) ? r.acc_loff : r.acc_hoff;
               lane_val = (l == 0) ? r.acc_dd[7:0] : r.acc_dd[15:8];
               if (lane_en) begin
                  case (lane_off)
                     OFF_DATA, OFF_DUP_EVEN: n.wr_lo = lane_val; // R10
                     OFF_DUP_ODD: begin
                        do_push = 1'b1; // R13
                        push_word = {lane_val, n.wr_lo};
                     end
                     OFF_ERRFEAT, OFF_ERRFEAT_COPY: n.feat = lane_val; // R11
                     OFF_COUNT: n.count = lane_val;
                     OFF_SECNUM: n.secnum = lane_val;
                     OFF_CYLLO: n.cyllo = lane_val;
                     OFF_CYLHI: n.cylhi = lane_val;
                     OFF_DEVHEAD: n.devhead = lane_val;
                     OFF_STATCMD: begin
                        do_cmd = 1'b1;
                        cmd_byte = lane_val;
                     end
                     OFF_ALTCTL: n.devctl = lane_val; // R2
                     default: n.wr_lo = n.wr_lo;
                  endcase
               end
            end
         end
      end

      // Words arriving with the FIFO full are dropped; the request bit is
      // already low then, so a well-behaved host never sends them.
      if (do_push && r.phase == PH_XFER && !r.xfer_rd && fifo_in_ready) begin
         n.push = 1'b1;
         n.push_data = push_word;
         n.words_left = r.words_left - 16'h0001;
         if (r.words_left == 16'h0001) begin
            n.phase = PH_IDLE; // R8
            n.pend = 1'b1;
         end
      end
      if (do_cmd) begin
         n.pend = 1'b0; // R16
         if (n.devhead[DEVHEAD_DEV_BIT] == r.dev_s[1]) begin
            n.opcode = cmd_byte; // R15
            n.phase = PH_BUSY; // R5
            n.cmd_valid = 1'b1;
            n.err_flag = 1'b0;
         end
      end

      // ==================================================================
      // Command engine side.
      if (r.phase == PH_BUSY && xfer_start) begin
         n.xfer_rd = xfer_read;
         n.words_left = xfer_words;
         n.phase = (xfer_words == 16'h0000) ? PH_IDLE : PH_XFER;
         n.pend = n.pend || xfer_read;
      end
      if (r.phase != PH_IDLE && cmd_done) begin
         n.phase = PH_IDLE;
         n.err = cmd_err_code;
         n.err_flag = cmd_err_code != 8'h00;
         n.pend = 1'b1;
         if (r.opcode == CMD_DIAG) begin
            n = with_defaults(n); // R14
         end
      end
      if (r.devctl[DEVCTL_SRST_BIT]) begin
         n.phase = PH_IDLE;
         n.pend = 1'b0; // R16
         n = with_defaults(n);
      end
      n.intrq = n.pend && !r.devctl[DEVCTL_NIEN_BIT] &&
         r.devhead[DEVHEAD_DEV_BIT] == r.dev_s[1];

      if (srst) begin
         n = '0;
         n.s1 = pins;
         n.s2 = r.s1;
         n.mode_s = {r.mode_s[0], pcc_mode};
         n.dev_s = {r.dev_s[0], dev_id};
         n.dior_d = 1'b1;
         n.diow_d = 1'b1;
         n.phase = PH_IDLE; // R16
         n = with_defaults(n);
      end
   end

   always_ff @(posedge ref_clk) begin
      r <= n;
   end

   assign dd_out = r.dd_out;
   assign dd_oe = r.dd_oe;
   assign intrq = r.intrq;
   assign cmd_valid = r.cmd_valid;
   assign rd_ready = r.rd_ready;
   assign task_out = {r.opcode, r.feat, r.count, r.devhead[3:0], r.cylhi,
      r.cyllo, r.secnum}; // R9
endmodule

// File: verif/atf_task_file_port_props.sv
// Port checker for the task file register port.
// Assumes the host holds address and select steady while a strobe is low.
`timescale 1ns/100ps
// ====================================================================
// Properties
module atf_task_file_port_props
   import atf_pkg::*;
(
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic pcc_mode,
   input wire atf_pins_type pins,
   input wire logic [1:0] dd_oe,
   input wire logic intrq,
   input wire logic cmd_valid,
   input wire atf_task_type task_out
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (srst);
   // The answer lags the pins by two sync stages and one register.
   atf_pins_type q1, q2, q3, q4;
   logic s;
   always_ff @(posedge ref_clk) begin
      q1 <= pins;
      q2 <= q1;
      q3 <= q2;
      q4 <= q3;
   end
   assign s = !q3.dior_n && (q2 == q3) && (q3 == q4);
   property p_drive_only_read;
      dd_oe != 2'h0 |-> !q3.dior_n;
   endproperty
   a_drive_only_read: assert property (p_drive_only_read)
      else $error("bus driven outside a read");
   property p_both_cs;
      s && !pcc_mode && !q3.cs0_n && !q3.cs1_n |-> dd_oe == 2'h0;
   endproperty
   a_both_cs: assert property (p_both_cs)
      else $error("invalid address answered");
   property p_obsolete;
      s && !pcc_mode && q3.cs0_n && !q3.cs1_n && q3.da == 3'h7
         |-> !dd_oe[0];
   endproperty
   a_obsolete: assert property (p_obsolete)
      else $error("obsolete address drives bit 7");
   property p_ctl_silent;
      s && !pcc_mode && q3.cs0_n && !q3.cs1_n && q3.da != ATA_CTL_DA
         |-> dd_oe == 2'h0;
   endproperty
   a_ctl_silent: assert property (p_ctl_silent)
      else $error("unused control address answered");
   property p_cmd_lanes;
      s && !pcc_mode && !q3.cs0_n && q3.cs1_n
         |-> dd_oe == ((q3.da == 3'h0) ? 2'h3 : 2'h1);
   endproperty
   a_cmd_lanes: assert property (p_cmd_lanes)
      else $error("wrong lanes on command block read");
   property p_card_lanes;
      s && pcc_mode && q3.addr inside {4'h0, 4'h1, 4'h8, 4'h9}
         |-> dd_oe == {~q3.ce2_n, ~q3.ce1_n};
   endproperty
   a_card_lanes: assert property (p_card_lanes)
      else $error("wrong lanes on card data read");
   property p_cmd_clears;
      cmd_valid |-> ##[0:2] !intrq;
   endproperty
   a_cmd_clears: assert property (p_cmd_clears)
      else $error("interrupt kept after command write");
   property p_reset_vals;
      $fell(srst) |-> dd_oe == 2'h0 && !intrq && !cmd_valid
         && task_out.count == RST_COUNT && task_out.lba ==
         {RST_DEVHEAD[3:0], RST_CYLHI, RST_CYLLO, RST_SECNUM};
   endproperty
   a_reset_vals: assert property (p_reset_vals)
      else $error("wrong state after reset");
endmodule

// File: verif/atf_host_model.sv
// Host adapter model driving the task file pins.
// Assumes the caller writes command block registers other than the data register only while idle.
`timescale 1ns/100ps
// ====================================================================
// Host
module atf_host_model
   import atf_pkg::*;
(
   input wire logic ref_clk,
   input wire logic [15:0] dd_out,
   input wire logic [1:0] dd_oe,
   output atf_pins_type pins
);
   initial begin
      pins = '1;
   end
   // One access: selects and address first, strobe low five cycles.
   // Bit 0 of sel_n is CS0-/CE#, bit 1 is CS1-/CE2#.
   task automatic io(input logic wr, input logic [1:0] sel_n,
      input logic [3:0] a, input logic [15:0] wd,
      output logic [15:0] rd, output logic [1:0] oe);
      @(negedge ref_clk);
      pins.cs0_n = sel_n[0];
      pins.ce1_n = sel_n[0];
      pins.cs1_n = sel_n[1];
      pins.ce2_n = sel_n[1];
      pins.da = a[2:0];
      pins.addr = a;
      if (wr) begin
         pins.dd = wd;
      end
      @(negedge ref_clk);
      if (wr) pins.diow_n = 1'b0;
      else pins.dior_n = 1'b0;
      repeat (5) @(negedge ref_clk);
      rd = dd_out & {{8{dd_oe[1]}}, {8{dd_oe[0]}}};
      oe = dd_oe;
      pins.dior_n = 1'b1;
      pins.diow_n = 1'b1;
      @(negedge ref_clk);
      // A released bus must not keep showing the last value.
      pins.dd = ~pins.dd;
      pins.cs0_n = 1'b1;
      pins.cs1_n = 1'b1;
      pins.ce1_n = 1'b1;
      pins.ce2_n = 1'b1;
      repeat (4) @(negedge ref_clk);
   endtask
endmodule

// File: verif/atf_task_file_port_tb.sv
// Self-checking bench for the task file register port.
// Assumes the host model and the checker are compiled first.
`timescale 1ns/100ps
// ====================================================================
// Bench
module atf_task_file_port_tb
   import atf_pkg::*;
;
   localparam logic [1:0] CB = 2'h2;
   localparam logic [1:0] CT = 2'h1;
   logic ref_clk = 1'b0, srst = 1'b1, pcc_mode = 1'b0, dev_id = 1'b0;
   logic xfer_start = 1'b0, xfer_read = 1'b0, cmd_done = 1'b0;
   logic rd_valid = 1'b1, wd_ready = 1'b0;
   logic [15:0] xfer_words = 16'h0000, rd_data = 16'ha500;
   logic [7:0] cmd_err_code = 8'h00;
   logic [15:0] dd_out, wd_data, r;
   logic [1:0] dd_oe, oe;
   logic intrq, cmd_valid, rd_ready, wd_valid;
   atf_pins_type pins;
   atf_task_type task_out;
   int fail_count = 0, checks_done = 0, cmd_seen = 0, rd_idx = 0;
   logic [15:0] got[$];
   logic [7:0] rv [2:6] = '{8'h01, 8'h01, 8'h00, 8'h00, 8'ha0};
   always #12.5 ref_clk = ~ref_clk;
   atf_host_model u_host (.ref_clk(ref_clk), .dd_out(dd_out),
      .dd_oe(dd_oe), .pins(pins));
   atf_task_file_port u_dut (.ref_clk(ref_clk), .srst(srst),
      .pcc_mode(pcc_mode), .dev_id(dev_id), .pins(pins),
      .dd_out(dd_out), .dd_oe(dd_oe), .intrq(intrq),
      .task_out(task_out), .cmd_valid(cmd_valid),
      .xfer_start(xfer_start), .xfer_read(xfer_read),
      .xfer_words(xfer_words), .cmd_done(cmd_done),
      .cmd_err_code(cmd_err_code), .rd_valid(rd_valid),
      .rd_data(rd_data), .rd_ready(rd_ready), .wd_valid(wd_valid),
      .wd_data(wd_data), .wd_ready(wd_ready));
   always @(posedge ref_clk) begin
      if (cmd_valid === 1'b1) cmd_seen++;
      if (rd_ready === 1'b1) rd_idx++;
      if (wd_valid === 1'b1 && wd_ready) got.push_back(wd_data);
   end
   // The read stream offers a new word once the last one is consumed.
   always @(negedge ref_clk) rd_data <= 16'ha500 + 16'(rd_idx);
   task automatic chk(input string what, input logic [15:0] seen,
      input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         $display("ERROR %s expected %h seen %h", what, exp, seen);
         fail_count++;
      end
   endtask
   task automatic wr(input logic [1:0] sel, input logic [3:0] a,
      input logic [15:0] d);
      u_host.io(1'b1, sel, a, d, r, oe);
   endtask
   task automatic rd(input logic [1:0] sel, input logic [3:0] a);
      u_host.io(1'b0, sel, a, 16'h0000, r, oe);
   endtask
   task automatic eng(input logic st, input logic dir,
      input logic [15:0] n, input logic dn, input logic [7:0] e);
      @(negedge ref_clk);
      xfer_start = st;
      xfer_read = dir;
      xfer_words = n;
      cmd_done = dn;
      cmd_err_code = e;
      @(negedge ref_clk);
      xfer_start = 1'b0;
      cmd_done = 1'b0;
      repeat (2) @(negedge ref_clk);
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge ref_clk);
      fail_count++;
      wrap_up();
   end
   initial begin
      repeat (5) @(posedge ref_clk);
      @(negedge ref_clk) srst = 1'b0;
      for (int i = 2; i < 7; i++) begin
         rd(CB, 4'(i));
         chk("reset value", r, {8'h00, rv[i]});
      end
      $display("reset values done");
      wr(CT, 4'h6, 16'h0000);
      wr(CB, 4'h1, 16'h005a);
      wr(CB, 4'h2, 16'h0002);
      wr(CB, 4'h3, 16'h0011);
      wr(CB, 4'h4, 16'h0022);
      wr(CB, 4'h5, 16'h0033);
      wr(CB, 4'h6, 16'h00e4);
      wr(CB, 4'h7, 16'h0020);
      chk("command pulses", 16'(cmd_seen), 16'h0001);
      chk("lba", task_out.lba[15:0], 16'h2211);
      chk("lba top", 16'(task_out.lba[27:16]), 16'h0433);
      chk("task", {task_out.opcode, task_out.features}, 16'h205a);
      rd(CB, 4'h7);
      chk("busy", 16'(r[7] | r[3]), 16'h0001);
      eng(1'b1, 1'b1, 16'h0002, 1'b0, 8'h00);
      rd(CT, 4'h6);
      chk("alt keeps irq", 16'(intrq), 16'h0001);
      rd(CB, 4'h7);
      chk("drq", 16'(r[3]), 16'h0001);
      chk("status clears irq", 16'(intrq), 16'h0000);
      @(negedge ref_clk) rd_valid = 1'b0;
      rd(CB, 4'h7);
      chk("no word stalls", 16'({r[7], r[3]}), 16'h0002);
      rd_valid = 1'b1;
      rd(CB, 4'h0);
      chk("word 0", r, 16'ha500);
      rd(CB, 4'h0);
      chk("word 1", r, 16'ha501);
      chk("done irq", 16'(intrq), 16'h0001);
      rd(CB, 4'h7);
      chk("idle after read", 16'({r[7], r[3]}), 16'h0000);
      $display("read transfer done");
      wr(CB, 4'h7, 16'h0030);
      eng(1'b1, 1'b0, 16'h0009, 1'b0, 8'h00);
      for (int i = 0; i < 8; i++) wr(CB, 4'h0, 16'hc000 + 16'(i));
      rd(CB, 4'h7);
      chk("full stalls", 16'({r[7], r[3]}), 16'h0002);
      @(negedge ref_clk) wd_ready = 1'b1;
      repeat (12) @(negedge ref_clk);
      wr(CB, 4'h0, 16'hc008);
      chk("fifo count", 16'(got.size()), 16'h0009);
      foreach (got[i]) chk("fifo word", got[i], 16'hc000 + 16'(i));
      rd(CB, 4'h7);
      chk("idle after write", 16'({r[7], r[3]}), 16'h0000);
      $display("write transfer done");
      rd(2'h0, 4'h0);
      chk("both selects", 16'(oe), 16'h0000);
      rd(CT, 4'h7);
      chk("obsolete", 16'(oe), 16'h0000);
      rd(CT, 4'h3);
      chk("unused control", 16'(oe), 16'h0000);
      rd(2'h3, 4'h7);
      chk("no select", 16'(oe), 16'h0000);
      wr(2'h0, 4'h2, 16'h0077);
      rd(CB, 4'h2);
      chk("invalid write dropped", r, 16'h0002);
      wr(CB, 4'h7, 16'h00ef);
      eng(1'b0, 1'b0, 16'h0000, 1'b1, 8'h04);
      chk("error irq", 16'(intrq), 16'h0001);
      wr(CT, 4'h6, 16'h0004);
      chk("srst clears irq", 16'(intrq), 16'h0000);
      wr(CT, 4'h6, 16'h0000);
      rd(CB, 4'h7);
      chk("err bit", 16'(r[0]), 16'h0001);
      rd(CB, 4'h1);
      chk("error", r, 16'h0004);
      @(negedge ref_clk) pcc_mode = 1'b1;
      repeat (6) @(negedge ref_clk);
      rd(2'h2, 4'hd);
      chk("error copy low", r, 16'h0004);
      rd(2'h0, 4'hc);
      chk("error copy high", r, 16'h0400);
      rd(2'h2, 4'h8);
      chk("even copy", r, 16'h0002);
      rd(2'h1, 4'h9);
      chk("odd high lane", r, 16'ha500);
      rd(2'h0, 4'h0);
      chk("card word", r, 16'ha502);
      @(negedge ref_clk) pcc_mode = 1'b0;
      repeat (6) @(negedge ref_clk);
      $display("card access done");
      wr(CB, 4'h2, 16'h0055);
      wr(CB, 4'h7, {8'h00, CMD_DIAG});
      eng(1'b0, 1'b0, 16'h0000, 1'b1, 8'h00);
      rd(CB, 4'h2);
      chk("diag count", r, 16'h0001);
      rd(CB, 4'h6);
      chk("diag head", r, 16'h00a0);
      wr(CB, 4'h6, 16'h00b0);
      wr(CB, 4'h7, 16'h0020);
      chk("other drive", 16'(cmd_seen), 16'h0004);
      @(negedge ref_clk) srst = 1'b1;
      repeat (2) @(negedge ref_clk);
      srst = 1'b0;
      rd(CB, 4'h6);
      chk("head after reset", r, 16'h00a0);
      $display("diagnostics and reset done");
      wrap_up();
   end
endmodule
bind atf_task_file_port atf_task_file_port_props u_props (
   .ref_clk(ref_clk), .srst(srst), .pcc_mode(pcc_mode), .pins(pins),
   .dd_oe(dd_oe), .intrq(intrq), .cmd_valid(cmd_valid),
   .task_out(task_out));
